// ==== core/iwd_consts.svh ====
// Constants of the indexed-port watchdog: ports, codes, offsets, fields, resets, timing.
// Assumes inclusion by bare name from the watchdog design files.
`ifndef IWD_CONSTS_SVH
`define IWD_CONSTS_SVH

// ==========================================
// Host I/O ports and access codes
`define IWD_INDEX_PORT 16'h002E
`define IWD_DATA_PORT 16'h002F
`define IWD_UNLOCK_CODE 8'h87
`define IWD_LOCK_CODE 8'hAA
`define IWD_FLOAT_DATA 8'hFF

// ==========================================
// Register indices and field positions
`define IWD_FUNC_SEL_OFS 8'h07
`define IWD_ACTIVATE_OFS 8'h30
`define IWD_TIME_BASE_OFS 8'hF5
`define IWD_COUNT_OFS 8'hF6
`define IWD_CTRL_STAT_OFS 8'hF7
`define IWD_WDT_FUNC_NUM 8'h08
`define IWD_ACT_ENABLE_BIT 0
`define IWD_UNIT_MIN_BIT 3
`define IWD_MOUSE_EN_BIT 7
`define IWD_KBD_EN_BIT 6
`define IWD_FORCE_BIT 5
`define IWD_TIMEOUT_BIT 4

// ==========================================
// Reset values
`define IWD_FUNC_SEL_RST 8'h00
`define IWD_COUNT_RST 8'h00

// ==========================================
// Timing
`define IWD_CLK_HZ 25000000
`define IWD_CLK_PERIOD_NS 40
`define IWD_TICK_S 1
`define IWD_SECS_PER_MIN 60
`define IWD_RST_PULSE_NS 1000
`define IWD_SEC_CYCLES (`IWD_CLK_HZ * `IWD_TICK_S)
`define IWD_RST_PULSE_CYC ((`IWD_RST_PULSE_NS + `IWD_CLK_PERIOD_NS - 1) / `IWD_CLK_PERIOD_NS)

`endif

// ==== core/iwd_pkg.sv ====
// Types of the indexed-port watchdog.
// Assumes nothing beyond a SystemVerilog compiler.
package iwd_pkg;

	// ==========================================
	// Configuration access state
	typedef enum logic [1:0] {
		IWD_LOCKED = 2'b00,
		IWD_UNLOCK1 = 2'b01,
		IWD_CONFIG = 2'b10
	} iwd_cfg_t;

	// ==========================================
	// Top state
	typedef struct packed {
		iwd_cfg_t cfg;
		logic [7:0] index;
		logic [7:0] ldn;
		logic act;
		logic unit_min;
		logic [7:0] load;
		logic [7:0] count;
		logic mouse_en;
		logic kbd_en;
		logic expired;
		logic [7:0] rst_cnt;
		logic rst;
		logic irq_n;
		logic [7:0] rdata;
		logic [2:0] mouse_s;
		logic [2:0] kbd_s;
		logic [1:0] strap_s;
		logic strap_irq;
		logic clr;
	} iwd_state_t;

	// ==========================================
	// Prescaler state
	typedef struct packed {
		logic [24:0] sec_cnt;
		logic [5:0] min_cnt;
		logic tick;
	} iwd_pre_t;

endpackage

// ==== core/iwd_tick_if.sv ====
// Link between the watchdog core and its time-base prescaler.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface iwd_tick_if;
	logic run;
	logic clr;
	logic min_sel;
	logic tick;
	modport core (output run, output clr, output min_sel, input tick);
	modport pre (input run, input clr, input min_sel, output tick);
endinterface

// ==== core/iwd_prescaler.sv ====
// Time-base prescaler: one tick per second or per minute while running.
// Assumes run and clr come from logic on the same clock.
`timescale 1ns/1ps
`include "iwd_consts.svh"
module iwd_prescaler
	import iwd_pkg::*;
#(
	parameter int unsigned SEC_CYCLES = `IWD_SEC_CYCLES
) (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	iwd_tick_if.pre tb
);
	import iwd_pkg::*;

	iwd_pre_t p_r;
	iwd_pre_t p_nxt;

	// ==========================================
	// Counting
	always_comb begin
		p_nxt = p_r;
		p_nxt.tick = 1'b0;
		if (tb.clr || !tb.run) begin
			// A restart starts a whole fresh period
			p_nxt.sec_cnt = '0;
			p_nxt.min_cnt = '0;
		end else if (p_r.sec_cnt == 25'(SEC_CYCLES - 1)) begin
			p_nxt.sec_cnt = '0;
			if (!tb.min_sel) begin
				p_nxt.tick = 1'b1;
			end else if (p_r.min_cnt == 6'(`IWD_SECS_PER_MIN - 1)) begin
				p_nxt.min_cnt = '0;
				p_nxt.tick = 1'b1;
			end else begin
				p_nxt.min_cnt = p_r.min_cnt + 6'h01;
			end
		end else begin
			p_nxt.sec_cnt = p_r.sec_cnt + 25'h0000001;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			p_r <= '0;
		end else begin
			p_r <= p_nxt;
		end
	end

	assign tb.tick = p_r.tick;

endmodule

// ==== core/iwd_top.sv ====
// Indexed-port watchdog timer: index/data host ports, unlock sequence, countdown and expiry outputs.
// Assumes host strobes on sys_clk_in; activity and strap inputs are asynchronous pins.
`timescale 1ns/1ps
`include "iwd_consts.svh"
module iwd_top
	import iwd_pkg::*;
#(
	parameter int unsigned SEC_CYCLES = `IWD_SEC_CYCLES
) (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic [15:0] io_addr_in,
	input wire logic io_wr_in,
	input wire logic io_rd_in,
	input wire logic [7:0] io_wdata_in,
	output logic [7:0] io_rdata_out,
	input wire logic mouse_act_in,
	input wire logic kbd_act_in,
	input wire logic reset_or_irq_strap_in,
	output logic wdt_reset_out,
	output logic wdt_irq_n_out
);
	import iwd_pkg::*;

	// ==========================================
	// Helpers
	function automatic logic port_hit(
		input logic [15:0] addr,
		input logic [15:0] port
	);
		port_hit = (addr == port);
	endfunction

	function automatic logic rise(
		input logic [2:0] sync
	);
		rise = sync[1] & ~sync[2];
	endfunction

	localparam iwd_state_t RESET_STATE = '{
		cfg: IWD_LOCKED,
		index: 8'h00,
		ldn: `IWD_FUNC_SEL_RST,
		act: 1'b0,
		unit_min: 1'b0,
		load: `IWD_COUNT_RST,
		count: `IWD_COUNT_RST,
		mouse_en: 1'b0,
		kbd_en: 1'b0,
		expired: 1'b0,
		rst_cnt: 8'h00,
		rst: 1'b0,
		irq_n: 1'b1,
		rdata: 8'h00,
		mouse_s: 3'h0,
		kbd_s: 3'h0,
		strap_s: 2'h0,
		strap_irq: 1'b0,
		clr: 1'b0
	};

	iwd_state_t s_r;
	iwd_state_t s_nxt;
	iwd_tick_if tb ();

	// ==========================================
	// Prescaler
	assign tb.run = s_r.act & (s_r.count != 8'h00) & ~s_r.expired;
	assign tb.clr = s_r.clr;
	assign tb.min_sel = s_r.unit_min;

	iwd_prescaler #(
		.SEC_CYCLES(SEC_CYCLES)
	) u_pre (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.tb(tb)
	);

	// ==========================================
	// Next state
	always_comb begin
		logic wr_idx;
		logic wr_dat;
		logic rd_idx;
		logic rd_dat;
		logic wd_regs;
		logic running;
		logic act_restart;
		logic cnt_write;
		logic force_to;
		logic expire;
		wr_idx = io_wr_in & port_hit(io_addr_in, `IWD_INDEX_PORT);
		wr_dat = io_wr_in & port_hit(io_addr_in, `IWD_DATA_PORT);
		rd_idx = io_rd_in & port_hit(io_addr_in, `IWD_INDEX_PORT);
		rd_dat = io_rd_in & port_hit(io_addr_in, `IWD_DATA_PORT);
		wd_regs = (s_r.cfg == IWD_CONFIG) && (s_r.ldn == `IWD_WDT_FUNC_NUM);
		running = s_r.act && (s_r.count != 8'h00) && !s_r.expired;
		act_restart = 1'b0;
		cnt_write = 1'b0;
		force_to = 1'b0;
		expire = 1'b0;
		s_nxt = s_r;
		s_nxt.clr = 1'b0;

		// Pin synchronisers; only the second stage onward is read
		s_nxt.mouse_s = {s_r.mouse_s[1:0], mouse_act_in};
		s_nxt.kbd_s = {s_r.kbd_s[1:0], kbd_act_in};
		s_nxt.strap_s = {s_r.strap_s[0], reset_or_irq_strap_in};
		s_nxt.strap_irq = s_r.strap_s[1];

		// Unlock and lock sequence on the index port
		unique case (s_r.cfg)
			IWD_LOCKED: begin
				if (wr_idx && io_wdata_in == `IWD_UNLOCK_CODE) begin
					s_nxt.cfg = IWD_UNLOCK1;
				end
			end
			IWD_UNLOCK1: begin
				if (wr_idx) begin
					if (io_wdata_in == `IWD_UNLOCK_CODE) begin
						s_nxt.cfg = IWD_CONFIG;
					end else begin
						s_nxt.cfg = IWD_LOCKED;
					end
				end else if (wr_dat || rd_dat) begin
					// Any data access breaks the pair of unlock writes
					s_nxt.cfg = IWD_LOCKED;
				end
			end
			IWD_CONFIG: begin
				if (wr_idx) begin
					if (io_wdata_in == `IWD_LOCK_CODE) begin
						s_nxt.cfg = IWD_LOCKED;
					end else begin
						s_nxt.index = io_wdata_in;
					end
				end
			end
			default: begin
				s_nxt.cfg = IWD_LOCKED;
			end
		endcase

		// Data port writes; ignored outside configuration mode
		if (wr_dat && s_r.cfg == IWD_CONFIG) begin
			if (s_r.index == `IWD_FUNC_SEL_OFS) begin
				s_nxt.ldn = io_wdata_in;
			end else if (wd_regs) begin
				case (s_r.index)
					`IWD_ACTIVATE_OFS: begin
						s_nxt.act = io_wdata_in[`IWD_ACT_ENABLE_BIT];
					end
					`IWD_TIME_BASE_OFS: begin
						s_nxt.unit_min = io_wdata_in[`IWD_UNIT_MIN_BIT];
					end
					`IWD_COUNT_OFS: begin
						cnt_write = 1'b1;
					end
					`IWD_CTRL_STAT_OFS: begin
						s_nxt.mouse_en = io_wdata_in[`IWD_MOUSE_EN_BIT];
						s_nxt.kbd_en = io_wdata_in[`IWD_KBD_EN_BIT];
						force_to = s_r.act & io_wdata_in[`IWD_FORCE_BIT];
					end
					default: begin
					end
				endcase
			end
		end

		// Countdown; a tick landing on the cycle after a restart is stale
		if (tb.tick && !s_r.clr && running) begin
			s_nxt.count = s_r.count - 8'h01;
			if (s_r.count == 8'h01) begin
				expire = 1'b1;
			end
		end

		// Activity restart reloads the last written count
		if (s_r.act && s_r.load != 8'h00) begin
			if (s_r.mouse_en && rise(s_r.mouse_s)) begin
				act_restart = 1'b1;
			end
			if (s_r.kbd_en && rise(s_r.kbd_s)) begin
				act_restart = 1'b1;
			end
		end
		if (act_restart) begin
			s_nxt.count = s_r.load;
			s_nxt.expired = 1'b0;
			s_nxt.clr = 1'b1;
		end

		// A count write wins over coincident activity and a tick's decrement, but not a final tick's expiry
		if (cnt_write) begin
			s_nxt.load = io_wdata_in;
			s_nxt.count = io_wdata_in;
			s_nxt.expired = 1'b0;
			s_nxt.clr = 1'b1;
		end

		// Expiry: the set wins over any clear in the same cycle
		if (s_r.rst_cnt != 8'h00) begin
			s_nxt.rst_cnt = s_r.rst_cnt - 8'h01;
		end
		if (expire || force_to) begin
			s_nxt.expired = 1'b1;
			if (!s_r.strap_irq) begin
				s_nxt.rst_cnt = 8'(`IWD_RST_PULSE_CYC);
			end
		end
		s_nxt.rst = (s_nxt.rst_cnt != 8'h00);
		s_nxt.irq_n = ~(s_nxt.expired & s_r.strap_irq);

		// Register reads; locked reads see a floating bus
		if (rd_idx || rd_dat) begin
			if (s_r.cfg != IWD_CONFIG) begin
				s_nxt.rdata = `IWD_FLOAT_DATA;
			end else if (rd_idx) begin
				s_nxt.rdata = s_r.index;
			end else if (s_r.index == `IWD_FUNC_SEL_OFS) begin
				s_nxt.rdata = s_r.ldn;
			end else if (!wd_regs) begin
				s_nxt.rdata = 8'h00;
			end else begin
				case (s_r.index)
					`IWD_ACTIVATE_OFS: begin
						s_nxt.rdata = {7'h00, s_r.act};
					end
					`IWD_TIME_BASE_OFS: begin
						s_nxt.rdata = {4'h0, s_r.unit_min, 3'h0};
					end
					`IWD_COUNT_OFS: begin
						// Shows the remaining count, not the reload value
						s_nxt.rdata = s_r.count;
					end
					`IWD_CTRL_STAT_OFS: begin
						s_nxt.rdata = {s_r.mouse_en, s_r.kbd_en, 1'b0, s_r.expired, 4'h0};
					end
					default: begin
						s_nxt.rdata = 8'h00;
					end
				endcase
			end
		end
	end

	// ==========================================
	// State register
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			s_r <= RESET_STATE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================
	// Outputs
	assign io_rdata_out = s_r.rdata;
	assign wdt_reset_out = s_r.rst;
	assign wdt_irq_n_out = s_r.irq_n;

endmodule

// ==== sim/iwd_checker_assertions.sv ====
// Checker for the indexed-port watchdog top, bound to its ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module iwd_checker
	import iwd_pkg::*;
#(
	parameter int unsigned SEC_CYCLES = 10
) (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic [15:0] io_addr_in,
	input wire logic io_wr_in,
	input wire logic io_rd_in,
	input wire logic [7:0] io_wdata_in,
	input wire logic [7:0] io_rdata_out,
	input wire logic mouse_act_in,
	input wire logic kbd_act_in,
	input wire logic reset_or_irq_strap_in,
	input wire logic wdt_reset_out,
	input wire logic wdt_irq_n_out
);
	typedef struct packed {
		logic [1:0] cfg;
		logic [7:0] idx;
		logic [7:0] fn;
		logic [4:0] rlen;
		logic [3:0] quiet;
	} iwd_chk_t;
	iwd_chk_t s_r;
	iwd_chk_t s_nxt;
	logic iw;
	logic dw;
	logic dr;
	assign iw = io_wr_in && io_addr_in == 16'h002E;
	assign dw = io_wr_in && io_addr_in == 16'h002F;
	assign dr = io_rd_in && io_addr_in == 16'h002F;
	// ==========================================
	// Shadow of the access state
	always_comb begin
		s_nxt = s_r;
		s_nxt.rlen = wdt_reset_out ? s_r.rlen + 5'h01 : 5'h00;
		s_nxt.quiet = (io_wr_in || mouse_act_in || kbd_act_in) ? 4'h0 : s_r.quiet + {3'h0, s_r.quiet != 4'hF};
		if (iw && io_wdata_in == 8'hAA) s_nxt.cfg = 2'h0;
		else if (iw && io_wdata_in == 8'h87 && s_r.cfg != 2'h2) s_nxt.cfg = s_r.cfg + 2'h1;
		else if (s_r.cfg == 2'h1 && (iw || dw || dr)) s_nxt.cfg = 2'h0;
		else if (iw && s_r.cfg == 2'h2) s_nxt.idx = io_wdata_in;
		if (dw && s_r.cfg == 2'h2 && s_r.idx == 8'h07) s_nxt.fn = io_wdata_in;
	end
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) s_r <= '0;
		else s_r <= s_nxt;
	end
	// ==========================================
	// Properties
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	rst_pulse_len_a: assert property ($fell(wdt_reset_out) |-> s_r.rlen == 5'h19)
		else $error("reset pulse width wrong");
	rst_pulse_max_a: assert property (s_r.rlen <= 5'h19)
		else $error("reset pulse too long");
	out_exclusive_a: assert property (!(wdt_reset_out && !wdt_irq_n_out))
		else $error("reset and interrupt both active");
	rdata_hold_a: assert property (!io_rd_in |=> $stable(io_rdata_out))
		else $error("read data changed without a read");
	locked_read_a: assert property (dr && s_r.cfg != 2'h2 |=> io_rdata_out == 8'hFF)
		else $error("locked read not floating value");
	irq_hold_a: assert property (!wdt_irq_n_out && s_r.quiet > 4'h8 |=> !wdt_irq_n_out)
		else $error("interrupt released without service");
	count_restart_a: assert property (dw && s_r.cfg == 2'h2 && s_r.idx == 8'hF6 && s_r.fn == 8'h08
		&& io_wdata_in != 8'h00 ##1 !io_wr_in |-> ##1 wdt_irq_n_out [*3]) else $error("count write did not restart");
	unit_read_a: assert property (dr && s_r.cfg == 2'h2 && s_r.idx == 8'hF5 && s_r.fn == 8'h08
		|=> (io_rdata_out & 8'hF7) == 8'h00) else $error("unit register stray bits");
	ctrl_read_a: assert property (dr && s_r.cfg == 2'h2 && s_r.idx == 8'hF7 && s_r.fn == 8'h08
		|=> (io_rdata_out & 8'h2F) == 8'h00) else $error("control register stray bits");
endmodule
bind iwd_top iwd_checker #(.SEC_CYCLES(SEC_CYCLES)) CHK (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
	.io_addr_in(io_addr_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_wdata_in(io_wdata_in),
	.io_rdata_out(io_rdata_out), .mouse_act_in(mouse_act_in), .kbd_act_in(kbd_act_in),
	.reset_or_irq_strap_in(reset_or_irq_strap_in), .wdt_reset_out(wdt_reset_out), .wdt_irq_n_out(wdt_irq_n_out));

// ==== sim/iwd_host_model.sv ====
// Host processor model: byte cycles on the index and data ports.
// Assumes the watchdog clock; strobes change on falling edges.
`timescale 1ns/1ps
module iwd_host_model (
	input wire logic clk_in,
	input wire logic [7:0] rdata_in,
	output logic [15:0] addr_out,
	output logic wr_out,
	output logic rd_out,
	output logic [7:0] wdata_out
);
	initial begin
		addr_out = 16'h0000;
		wr_out = 1'b0;
		rd_out = 1'b0;
		wdata_out = 8'h00;
	end
	// ==========================================
	// Port cycles
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(negedge clk_in);
		wr_out <= 1'b0;
		wdata_out <= ~d; // Released data must not look valid
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(negedge clk_in);
		rd_out <= 1'b0;
		@(negedge clk_in);
		d = rdata_in;
	endtask
	task automatic wreg(input logic [7:0] i, input logic [7:0] d);
		wr(16'h002E, i);
		wr(16'h002F, d);
	endtask
	task automatic rreg(input logic [7:0] i, output logic [7:0] d);
		wr(16'h002E, i);
		rd(16'h002F, d);
	endtask
	task unlock;
		wr(16'h002E, 8'h87);
		wr(16'h002E, 8'h87);
		wreg(8'h07, 8'h08);
	endtask
	task lock;
		wr(16'h002E, 8'hAA);
	endtask
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the indexed-port watchdog.
// Assumes the host model issues all port cycles.
`timescale 1ns/1ps
module tb_top;
	import iwd_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic strap = 1'b1;
	logic [1:0] act = 2'h0;
	logic [15:0] a;
	logic w;
	logic r;
	logic rst_o;
	logic irq_n;
	logic [7:0] wd;
	logic [7:0] rdat;
	logic [7:0] d;
	int err_total = 0;
	int checked = 0;
	int n;
	always #20 clk = ~clk;
	iwd_host_model HOST (.clk_in(clk), .rdata_in(rdat), .addr_out(a), .wr_out(w), .rd_out(r), .wdata_out(wd));
	iwd_top #(.SEC_CYCLES(10)) DUT (.sys_clk_in(clk), .sys_rst_in(rst), .io_addr_in(a), .io_wr_in(w),
		.io_rd_in(r), .io_wdata_in(wd), .io_rdata_out(rdat), .mouse_act_in(act[0]), .kbd_act_in(act[1]),
		.reset_or_irq_strap_in(strap), .wdt_reset_out(rst_o), .wdt_irq_n_out(irq_n));
	// ==========================================
	// Helpers
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wt(input int c);
		repeat (c) @(negedge clk);
	endtask
	task wlow(input int mx);
		n = 0;
		while (irq_n !== 1'b0 && n < mx) begin
			@(negedge clk);
			n++;
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// ==========================================
	// Tests
	task t_locked;
		HOST.rd(16'h002F, d);
		chk("locked rd", d, 8'hFF);
		HOST.wreg(8'hF6, 8'h05);
		HOST.wr(16'h002E, 8'h87);
		HOST.wr(16'h002E, 8'h07);
		HOST.wr(16'h002E, 8'h87);
		HOST.rd(16'h002F, d);
		chk("broken unlock", d, 8'hFF);
		HOST.unlock;
		HOST.rd(16'h002E, d);
		chk("index rd", d, 8'h07);
		HOST.wreg(8'h07, 8'h00);
		HOST.wreg(8'hF6, 8'h05);
		HOST.rreg(8'hF6, d);
		chk("fn gated", d, 8'h00);
		HOST.wreg(8'h07, 8'h08);
		HOST.rreg(8'hF6, d);
		chk("count", d, 8'h00);
		HOST.rreg(8'hF5, d);
		chk("unit", d, 8'h00);
		HOST.wreg(8'hF7, 8'h20);
		HOST.rreg(8'hF7, d);
		chk("ctrl", d, 8'h00);
		HOST.lock;
		HOST.rd(16'h002F, d);
		chk("relocked rd", d, 8'hFF);
		$display("test locked done");
	endtask
	task t_count;
		HOST.unlock;
		HOST.wreg(8'h30, 8'h01);
		HOST.wreg(8'hF6, 8'h03);
		wt(20);
		HOST.wreg(8'hF6, 8'h03);
		wlow(60);
		chk("restart", {7'h0, n >= 27 && n <= 34}, 8'h01);
		HOST.rreg(8'hF7, d);
		chk("status", d & 8'h10, 8'h10);
		wt(12);
		chk("irq held", {7'h0, irq_n}, 8'h00);
		HOST.wreg(8'hF6, 8'h00);
		wt(60);
		chk("irq clr", {7'h0, irq_n}, 8'h01);
		HOST.wreg(8'hF5, 8'h08);
		HOST.rreg(8'hF5, d);
		chk("minutes", d, 8'h08);
		HOST.wreg(8'hF6, 8'h01);
		wlow(700);
		chk("minute", {7'h0, n >= 595 && n <= 606}, 8'h01);
		HOST.wreg(8'hF6, 8'h00);
		HOST.wreg(8'hF5, 8'h00);
		HOST.wreg(8'h30, 8'h00);
		HOST.wreg(8'hF6, 8'h01);
		wt(30);
		chk("disabled", {7'h0, irq_n}, 8'h01);
		HOST.rreg(8'hF6, d);
		chk("held count", d, 8'h01);
		HOST.wreg(8'hF6, 8'h00);
		HOST.wreg(8'h30, 8'h01);
		$display("test count done");
	endtask
	task t_force;
		strap <= 1'b0;
		wt(4);
		HOST.wreg(8'hF7, 8'h20);
		chk("force", {7'h0, rst_o}, 8'h01);
		n = 0;
		repeat (40) begin
			n += rst_o;
			wt(1);
		end
		chk("pulse", n[7:0], 8'h19);
		chk("no irq", {7'h0, irq_n}, 8'h01);
		HOST.rreg(8'hF7, d);
		chk("force stat", d & 8'h30, 8'h10);
		HOST.wreg(8'hF6, 8'h00);
		strap <= 1'b1;
		wt(4);
		$display("test force done");
	endtask
	task t_act;
		for (int k = 0; k < 2; k++) begin
			HOST.wreg(8'hF7, k ? 8'h40 : 8'h80);
			HOST.wreg(8'hF6, 8'h02);
			repeat (5) begin
				wt(10);
				act[k] <= 1'b1;
				wt(2);
				act[k] <= 1'b0;
			end
			chk("act", {7'h0, irq_n}, 8'h01);
			wlow(40);
			chk("act exp", {7'h0, n < 40}, 8'h01);
			act[1 - k] <= 1'b1;
			wt(2);
			act[1 - k] <= 1'b0;
			wt(8);
			chk("masked", {7'h0, irq_n}, 8'h00);
			HOST.wreg(8'hF6, 8'h00);
		end
		HOST.lock;
		$display("test activity done");
	endtask
	initial begin
		#400000;
		err_total++;
		end_sim;
	end
	initial begin
		wt(5);
		rst <= 1'b0;
		wt(4);
		t_locked;
		t_count;
		t_force;
		t_act;
		end_sim;
	end
endmodule
